// file: iod_pkg.sv
/*
 Shared types and constants of the low I/O register space decoder.
 Assumes one system clock and an active-low asynchronous reset.
*/
package iod_pkg;

	// -------------------------------------------------------------
	// Access operations issued by the core
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		IOD_IO_READ = 3'h0,
		IOD_IO_WRITE = 3'h1,
		IOD_SET_BIT_INSTR = 3'h2,
		IOD_CLEAR_BIT_INSTR = 3'h3,
		IOD_SKIP_IF_BIT_SET_INSTR = 3'h4,
		IOD_SKIP_IF_BIT_CLEAR_INSTR = 3'h5,
		IOD_DATA_LOAD = 3'h6,
		IOD_DATA_STORE = 3'h7
	} iod_op_t;

	// -------------------------------------------------------------
	// I/O offsets
	// -------------------------------------------------------------
	localparam logic [5:0] IOD_PORT_A_INPUT = 6'h00;
	localparam logic [5:0] IOD_PORT_A_DIRECTION = 6'h01;
	localparam logic [5:0] IOD_PORT_A_OUTPUT = 6'h02;
	localparam logic [5:0] IOD_PORT_B_INPUT = 6'h03;
	localparam logic [5:0] IOD_PORT_B_DIRECTION = 6'h04;
	localparam logic [5:0] IOD_PORT_B_OUTPUT = 6'h05;
	localparam logic [5:0] IOD_PORT_C_INPUT = 6'h06;
	localparam logic [5:0] IOD_PORT_C_DIRECTION = 6'h07;
	localparam logic [5:0] IOD_PORT_C_OUTPUT = 6'h08;
	localparam logic [5:0] IOD_PORT_D_INPUT = 6'h09;
	localparam logic [5:0] IOD_PORT_D_DIRECTION = 6'h0a;
	localparam logic [5:0] IOD_PORT_D_OUTPUT = 6'h0b;
	localparam logic [5:0] IOD_PORT_E_INPUT = 6'h0c;
	localparam logic [5:0] IOD_PORT_E_DIRECTION = 6'h0d;
	localparam logic [5:0] IOD_PORT_E_OUTPUT = 6'h0e;
	localparam logic [5:0] IOD_PORT_F_INPUT = 6'h0f;
	localparam logic [5:0] IOD_PORT_F_DIRECTION = 6'h10;
	localparam logic [5:0] IOD_PORT_F_OUTPUT = 6'h11;
	localparam logic [5:0] IOD_TIMER_ZERO_FLAGS = 6'h15;
	localparam logic [5:0] IOD_TIMER_ONE_FLAGS = 6'h16;
	localparam logic [5:0] IOD_TIMER_TWO_FLAGS = 6'h17;
	localparam logic [5:0] IOD_TIMER_THREE_FLAGS = 6'h18;
	localparam logic [5:0] IOD_PIN_CHANGE_FLAGS = 6'h1b;
	localparam logic [5:0] IOD_EXTERNAL_IRQ_FLAGS = 6'h1c;
	localparam logic [5:0] IOD_EXTERNAL_IRQ_MASK = 6'h1d;
	localparam logic [5:0] IOD_GENERAL_SCRATCH_ZERO = 6'h1e;
	localparam logic [5:0] IOD_NV_MEMORY_CONTROL = 6'h1f;
	localparam logic [5:0] IOD_NV_MEMORY_DATA = 6'h20;
	localparam logic [5:0] IOD_NV_ADDRESS_LOW = 6'h21;
	localparam logic [5:0] IOD_NV_ADDRESS_HIGH = 6'h22;
	localparam logic [5:0] IOD_GLOBAL_TIMER_CONTROL = 6'h23;
	localparam logic [5:0] IOD_TIMER_ZERO_CONTROL_A = 6'h24;
	localparam logic [5:0] IOD_TIMER_ZERO_CONTROL_B = 6'h25;
	localparam logic [5:0] IOD_TIMER_ZERO_COUNT = 6'h26;
	localparam logic [5:0] IOD_TIMER_ZERO_COMPARE_A = 6'h27;
	localparam logic [5:0] IOD_TIMER_ZERO_COMPARE_B = 6'h28;
	localparam logic [5:0] IOD_PLL_CONTROL_STATUS = 6'h29;
	localparam logic [5:0] IOD_BITOP_LAST = 6'h1f;

	// -------------------------------------------------------------
	// Data-space windows
	// -------------------------------------------------------------
	localparam logic [15:0] IOD_DATA_IO_FIRST = 16'h0020;
	localparam logic [15:0] IOD_DATA_IO_LAST = 16'h005f;
	localparam logic [15:0] IOD_EXT_FIRST = 16'h0060;
	localparam logic [15:0] IOD_EXT_LAST = 16'h01ff;

	// -------------------------------------------------------------
	// Groups, masks and reset values
	// -------------------------------------------------------------
	localparam int IOD_PORT_COUNT = 6;
	localparam int IOD_FLAG_COUNT = 6;
	localparam int IOD_SYNC_WIDTH = IOD_PORT_COUNT * 8 + 1;
	localparam int IOD_MEM_DEPTH = 16;
	localparam int IOD_MEM_AW = 4;
	localparam logic [5:0] IOD_MEM_BASE = IOD_EXTERNAL_IRQ_MASK;
	localparam int IOD_PLL_LOCK_BIT = 0;
	localparam logic [7:0] IOD_MASK_ALL = 8'hff;
	localparam logic [7:0] IOD_NV_CONTROL_MASK = 8'h3f;
	localparam logic [7:0] IOD_NV_ADDR_HIGH_MASK = 8'h0f;
	localparam logic [7:0] IOD_GLOBAL_TIMER_MASK = 8'h83;
	localparam logic [7:0] IOD_TIMER_ZERO_A_MASK = 8'hf3;
	localparam logic [7:0] IOD_TIMER_ZERO_B_MASK = 8'hcf;
	localparam logic [7:0] IOD_PLL_READ_MASK = 8'h1f;
	localparam logic [7:0] IOD_PLL_WRITE_MASK = 8'h1e;
	localparam logic [7:0] IOD_RESET_BYTE = 8'h00;
	localparam logic [7:0] IOD_DIR_N_RESET = 8'hff;

	typedef logic [IOD_PORT_COUNT-1:0][7:0] iod_port_bytes_t;
	typedef logic [IOD_FLAG_COUNT-1:0][7:0] iod_flag_bytes_t;

	localparam logic [5:0] IOD_PIN_OFS [IOD_PORT_COUNT] = '{IOD_PORT_A_INPUT,
		IOD_PORT_B_INPUT, IOD_PORT_C_INPUT, IOD_PORT_D_INPUT,
		IOD_PORT_E_INPUT, IOD_PORT_F_INPUT};
	localparam logic [5:0] IOD_DIR_OFS [IOD_PORT_COUNT] = '{
		IOD_PORT_A_DIRECTION, IOD_PORT_B_DIRECTION, IOD_PORT_C_DIRECTION,
		IOD_PORT_D_DIRECTION, IOD_PORT_E_DIRECTION, IOD_PORT_F_DIRECTION};
	localparam logic [5:0] IOD_OUT_OFS [IOD_PORT_COUNT] = '{
		IOD_PORT_A_OUTPUT, IOD_PORT_B_OUTPUT, IOD_PORT_C_OUTPUT,
		IOD_PORT_D_OUTPUT, IOD_PORT_E_OUTPUT, IOD_PORT_F_OUTPUT};
	localparam logic [5:0] IOD_FLAG_OFS [IOD_FLAG_COUNT] = '{
		IOD_TIMER_ZERO_FLAGS, IOD_TIMER_ONE_FLAGS, IOD_TIMER_TWO_FLAGS,
		IOD_TIMER_THREE_FLAGS, IOD_PIN_CHANGE_FLAGS, IOD_EXTERNAL_IRQ_FLAGS};
	localparam logic [7:0] IOD_FLAG_MASK [IOD_FLAG_COUNT] = '{8'h07, 8'h2f,
		8'h07, 8'h2f, 8'h01, 8'hff};

	// -------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------
	typedef struct packed {
		iod_op_t op;
		logic [15:0] addr;
		logic [2:0] bitn;
		logic [7:0] wdata;
	} iod_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic skip;
		logic [7:0] rdata;
	} iod_ans_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [8:0] addr;
		logic [7:0] wdata;
	} iod_ext_t;

	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [7:0] data;
	} iod_note_t;

	typedef struct packed {
		logic io_hit;
		logic ext_hit;
		logic [5:0] io_addr;
	} iod_dec_t;

endpackage : iod_pkg

// file: iod_sync2.sv
/*
 Two-flop synchroniser for a bundle of levels.
 Assumes the inputs are unrelated to clk_sys.
*/
`timescale 1ns/1ps
module iod_sync2
	import iod_pkg::*;
#(
	parameter int W = 1
)
(
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset
	input wire logic [W-1:0] d, // Raw levels
	output logic [W-1:0] q // Synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} iod_sync_state_t;

	iod_sync_state_t st;
	iod_sync_state_t next_st;

	always_comb
	begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;
endmodule : iod_sync2

// file: iod_regmem.sv
/*
 Small register memory holding the plain control registers.
 Assumes one write port and one read port on clk_sys.
*/
`timescale 1ns/1ps
module iod_regmem
	import iod_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset
	input wire logic we, // Write strobe
	input wire logic [IOD_MEM_AW-1:0] waddr, // Write index
	input wire logic [7:0] wdata, // Write byte
	input wire logic [IOD_MEM_AW-1:0] raddr, // Read index
	output logic [7:0] rdata // Registered read byte
);
	typedef struct packed {
		logic [IOD_MEM_DEPTH-1:0][7:0] mem;
		logic [7:0] rdata;
	} iod_mem_state_t;

	iod_mem_state_t st;
	iod_mem_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.rdata = st.mem[raddr];
		if (we)
			next_st.mem[waddr] = wdata;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign rdata = st.rdata;
endmodule : iod_regmem

// file: iod_top.sv
/*
 Decoder and access logic of the low I/O register space.
 Assumes the core holds req stable while req_valid and not req_ready;
 flag_event and ext_rdata come from logic on clk_sys.
*/
`timescale 1ns/1ps

// Overview of operation
// - Bit set/clear only at 0x00 to 0x1F
// - Skip instructions test any bit in range
// - Some flags clear on writing one
// - Bit set/clear rewrites whole register, clearing flags
// - I/O instructions address 0x00 to 0x3F
// - Data-space address is I/O address plus 0x20
// - Extended range only through data-space access
module iod_top
	import iod_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset
	input wire logic req_valid, // Access request
	input wire iod_req_t req, // Request fields
	output logic req_ready, // Request taken when high
	output iod_ans_t ans, // Answer, ack one cycle
	output iod_ext_t ext, // Extended space strobe
	input wire logic [7:0] ext_rdata, // Extended space read data
	output iod_note_t note, // Control register write notice
	input wire iod_port_bytes_t pin_in, // Pin levels
	output iod_port_bytes_t pin_out, // Pin drive values
	output iod_port_bytes_t pin_oe_n, // Pin drive enables
	input wire logic pll_lock_raw, // PLL lock level
	input wire iod_flag_bytes_t flag_event // Flag set pulses
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_ACCESS = 2'h2
	} iod_state_t;

	typedef struct packed {
		iod_state_t state;
		logic ready;
		iod_req_t req;
		iod_port_bytes_t port_out;
		iod_port_bytes_t dir_n;
		iod_flag_bytes_t flag;
		iod_ans_t ans;
		iod_ext_t ext;
		iod_note_t note;
	} iod_top_state_t;

	iod_top_state_t st;
	iod_top_state_t next_st;

	logic [IOD_SYNC_WIDTH-1:0] sync_q;
	iod_port_bytes_t pin_s;
	logic pll_lock_s;
	iod_dec_t dec_in;
	iod_dec_t dec;
	logic take;
	logic access;
	logic is_bitop;
	logic is_skip;
	logic is_write;
	logic deny;
	logic wr_en;
	logic [7:0] cur;
	logic [7:0] cur_m;
	logic [7:0] rmask;
	logic [7:0] wmask;
	logic [7:0] bit_m;
	logic [7:0] wr_val;
	logic bit_val;
	logic [IOD_PORT_COUNT-1:0] dir_hit;
	logic [IOD_PORT_COUNT-1:0] out_hit;
	logic [IOD_FLAG_COUNT-1:0] flag_hit;
	iod_flag_bytes_t flag_clr;
	logic mem_hit;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic [IOD_MEM_AW-1:0] mem_raddr;
	logic [IOD_MEM_AW-1:0] mem_waddr;

	// ---------------------------------------------------------------
	// Pin synchronisers and control register memory
	// ---------------------------------------------------------------
	iod_sync2 #(
		.W(IOD_SYNC_WIDTH)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.d({pll_lock_raw, pin_in}),
		.q(sync_q)
	);

	assign pin_s = sync_q[IOD_SYNC_WIDTH-2:0];
	assign pll_lock_s = sync_q[IOD_SYNC_WIDTH-1];

	iod_regmem u_mem (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(wr_val & wmask),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	function automatic iod_dec_t decode(input iod_req_t r);
		iod_dec_t d;
		d = '0;
		if (r.op == IOD_DATA_LOAD || r.op == IOD_DATA_STORE)
		begin
			if (r.addr >= IOD_DATA_IO_FIRST && r.addr <= IOD_DATA_IO_LAST)
			begin
				d.io_hit = 1'b1;
				d.io_addr = 6'(r.addr - IOD_DATA_IO_FIRST);
			end
			else if (r.addr >= IOD_EXT_FIRST && r.addr <= IOD_EXT_LAST)
				d.ext_hit = 1'b1;
		end
		else
		begin
			d.io_hit = 1'b1;
			d.io_addr = r.addr[5:0];
		end
		return d;
	endfunction : decode

	function automatic logic [7:0] misc_rmask(input logic [5:0] a);
		case (a)
			IOD_NV_MEMORY_CONTROL: misc_rmask = IOD_NV_CONTROL_MASK;
			IOD_NV_ADDRESS_HIGH: misc_rmask = IOD_NV_ADDR_HIGH_MASK;
			IOD_GLOBAL_TIMER_CONTROL: misc_rmask = IOD_GLOBAL_TIMER_MASK;
			IOD_TIMER_ZERO_CONTROL_A: misc_rmask = IOD_TIMER_ZERO_A_MASK;
			IOD_TIMER_ZERO_CONTROL_B: misc_rmask = IOD_TIMER_ZERO_B_MASK;
			IOD_PLL_CONTROL_STATUS: misc_rmask = IOD_PLL_READ_MASK;
			IOD_EXTERNAL_IRQ_MASK,
			IOD_GENERAL_SCRATCH_ZERO,
			IOD_NV_MEMORY_DATA,
			IOD_NV_ADDRESS_LOW,
			IOD_TIMER_ZERO_COUNT,
			IOD_TIMER_ZERO_COMPARE_A,
			IOD_TIMER_ZERO_COMPARE_B: misc_rmask = IOD_MASK_ALL;
			default: misc_rmask = '0;
		endcase
	endfunction : misc_rmask

	assign dec_in = decode(req);
	assign dec = decode(st.req);
	assign take = req_valid && st.ready && st.state == ST_IDLE;
	assign access = st.state == ST_ACCESS;
	assign mem_raddr = IOD_MEM_AW'(dec_in.io_addr - IOD_MEM_BASE);
	assign mem_waddr = IOD_MEM_AW'(dec.io_addr - IOD_MEM_BASE);

	// ---------------------------------------------------------------
	// Operation class and range limits
	// ---------------------------------------------------------------
	always_comb
	begin
		is_bitop = st.req.op == IOD_SET_BIT_INSTR ||
			st.req.op == IOD_CLEAR_BIT_INSTR;
		is_skip = st.req.op == IOD_SKIP_IF_BIT_SET_INSTR ||
			st.req.op == IOD_SKIP_IF_BIT_CLEAR_INSTR;
		is_write = is_bitop || st.req.op == IOD_IO_WRITE ||
			st.req.op == IOD_DATA_STORE;
		deny = (is_bitop || is_skip) && dec.io_addr > IOD_BITOP_LAST;
		wr_en = access && dec.io_hit && is_write && !deny;
	end

	// ---------------------------------------------------------------
	// Read mux and masks
	// ---------------------------------------------------------------
	always_comb
	begin
		cur = '0;
		rmask = '0;
		wmask = '0;
		dir_hit = '0;
		out_hit = '0;
		flag_hit = '0;
		mem_hit = 1'b0;
		for (int k = 0; k < IOD_PORT_COUNT; k++)
		begin
			if (dec.io_addr == IOD_PIN_OFS[k])
			begin
				cur = pin_s[k];
				rmask = IOD_MASK_ALL;
			end
			if (dec.io_addr == IOD_DIR_OFS[k])
			begin
				cur = ~st.dir_n[k];
				rmask = IOD_MASK_ALL;
				wmask = IOD_MASK_ALL;
				dir_hit[k] = 1'b1;
			end
			if (dec.io_addr == IOD_OUT_OFS[k])
			begin
				cur = st.port_out[k];
				rmask = IOD_MASK_ALL;
				wmask = IOD_MASK_ALL;
				out_hit[k] = 1'b1;
			end
		end
		for (int f = 0; f < IOD_FLAG_COUNT; f++)
		begin
			if (dec.io_addr == IOD_FLAG_OFS[f])
			begin
				cur = st.flag[f];
				rmask = IOD_FLAG_MASK[f];
				wmask = IOD_FLAG_MASK[f];
				flag_hit[f] = 1'b1;
			end
		end
		if (dec.io_addr >= IOD_MEM_BASE &&
			dec.io_addr <= IOD_PLL_CONTROL_STATUS)
		begin
			mem_hit = 1'b1;
			cur = mem_rdata;
			rmask = misc_rmask(dec.io_addr);
			wmask = rmask;
			if (dec.io_addr == IOD_PLL_CONTROL_STATUS)
			begin
				cur[IOD_PLL_LOCK_BIT] = pll_lock_s;
				wmask = IOD_PLL_WRITE_MASK;
			end
		end
		if (!dec.io_hit)
		begin
			rmask = '0;
			wmask = '0;
		end
		cur_m = cur & rmask;
	end

	// ---------------------------------------------------------------
	// Write value, including read-modify-write of bit operations
	// ---------------------------------------------------------------
	always_comb
	begin
		bit_m = 8'(8'h01 << st.req.bitn);
		bit_val = cur_m[st.req.bitn];
		case (st.req.op)
			IOD_SET_BIT_INSTR: wr_val = cur_m | bit_m;
			IOD_CLEAR_BIT_INSTR: wr_val = cur_m & ~bit_m;
			IOD_IO_WRITE,
			IOD_DATA_STORE: wr_val = st.req.wdata;
			default: wr_val = '0;
		endcase
		mem_we = wr_en && mem_hit && wmask != '0;
		for (int f = 0; f < IOD_FLAG_COUNT; f++)
			flag_clr[f] = (wr_en && flag_hit[f]) ?
				(wr_val & IOD_FLAG_MASK[f]) : '0;
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.ans = '0;
		next_st.ext.rd = 1'b0;
		next_st.ext.wr = 1'b0;
		next_st.note.wr = 1'b0;
		for (int f = 0; f < IOD_FLAG_COUNT; f++)
			next_st.flag[f] = (st.flag[f] & ~flag_clr[f]) |
				(flag_event[f] & IOD_FLAG_MASK[f]);
		case (st.state)
			ST_IDLE:
			begin
				if (take)
				begin
					next_st.state = ST_ACCESS;
					next_st.ready = 1'b0;
					next_st.req = req;
					next_st.ext.rd = dec_in.ext_hit && req.op == IOD_DATA_LOAD;
					next_st.ext.wr = dec_in.ext_hit && req.op == IOD_DATA_STORE;
					next_st.ext.addr = req.addr[8:0];
					next_st.ext.wdata = req.wdata;
				end
			end
			ST_ACCESS:
			begin
				next_st.state = ST_IDLE;
				next_st.ready = 1'b1;
				next_st.ans.ack = 1'b1;
				next_st.ans.err = deny || !(dec.io_hit || dec.ext_hit);
				next_st.ans.rdata = st.ext.rd ? ext_rdata :
					(deny ? '0 : cur_m);
				if (is_skip && !deny)
					next_st.ans.skip =
						(st.req.op == IOD_SKIP_IF_BIT_SET_INSTR) ?
						bit_val : !bit_val;
				for (int k = 0; k < IOD_PORT_COUNT; k++)
				begin
					if (wr_en && out_hit[k])
						next_st.port_out[k] = wr_val;
					if (wr_en && dir_hit[k])
						next_st.dir_n[k] = ~wr_val;
				end
				next_st.note.wr = mem_we;
				next_st.note.addr = dec.io_addr;
				next_st.note.data = wr_val & wmask;
			end
			default:
			begin
				next_st.state = ST_IDLE;
				next_st.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.state <= ST_IDLE;
			st.ready <= 1'b1;
			st.port_out <= '{default: IOD_RESET_BYTE};
			st.dir_n <= '{default: IOD_DIR_N_RESET};
		end
		else
			st <= next_st;
	end

	assign req_ready = st.ready;
	assign ans = st.ans;
	assign ext = st.ext;
	assign note = st.note;
	assign pin_out = st.port_out;
	assign pin_oe_n = st.dir_n;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	chk_bitop_range: assert property (
		take && (req.op == IOD_SET_BIT_INSTR ||
		req.op == IOD_CLEAR_BIT_INSTR) && req.addr[5:0] > IOD_BITOP_LAST
		|-> ##1 !wr_en ##1 (ans.ack && ans.err))
		else $error("bit operation above bit range was not refused");

	chk_skip_value: assert property (
		access && is_skip && !deny
		|=> ans.ack && !ans.err &&
		ans.skip == ($past(st.req.op) == IOD_SKIP_IF_BIT_SET_INSTR ?
		$past(bit_val) : !$past(bit_val)))
		else $error("skip answer does not match tested bit");

	chk_w1c_clear: assert property (
		access && wr_en && flag_hit != '0 &&
		flag_event == '0
		|=> (st.flag[$past(dec.io_addr) - IOD_TIMER_ZERO_FLAGS] &
		$past(wr_val)) == 8'h00 || $past(dec.io_addr) > IOD_TIMER_THREE_FLAGS)
		else $error("written one did not clear timer flag");

	chk_rmw_clears: assert property (
		access && st.req.op == IOD_SET_BIT_INSTR && !deny &&
		flag_hit[0] && flag_event == '0
		|=> st.flag[0] == 8'h00)
		else $error("bit set on flag register left a flag standing");

	chk_io_window: assert property (
		take && (req.op == IOD_IO_READ || req.op == IOD_IO_WRITE)
		|=> dec.io_hit && !dec.ext_hit && !ext.rd && !ext.wr &&
		dec.io_addr == $past(req.addr[5:0]))
		else $error("I/O instruction decoded outside the I/O window");

	chk_data_offset: assert property (
		take && req.op == IOD_DATA_LOAD &&
		req.addr >= IOD_DATA_IO_FIRST && req.addr <= IOD_DATA_IO_LAST
		|=> dec.io_hit && 16'(dec.io_addr) + IOD_DATA_IO_FIRST ==
		$past(req.addr))
		else $error("data-space offset of I/O register is wrong");

	chk_ext_only_data: assert property (
		(ext.rd || ext.wr)
		|-> access && st.req.addr >= IOD_EXT_FIRST &&
		st.req.addr <= IOD_EXT_LAST && (st.req.op == IOD_DATA_LOAD ||
		st.req.op == IOD_DATA_STORE) ##1 ans.ack && !ans.err)
		else $error("extended strobe without data-space access");

	chk_reserved_zero: assert property (
		access && dec.io_hit && rmask == '0
		|-> !mem_we && flag_clr == '0 ##1 ans.ack && ans.rdata == 8'h00)
		else $error("reserved location read nonzero or was written");

endmodule : iod_top

// file: iod_ext_model.sv
/*
 Extended I/O space model that answers the decoder's ext strobes.
 Assumes ext is driven by iod_top on clk_sys.
*/
`timescale 1ns/1ps
module iod_ext_model
	import iod_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset
	input wire iod_ext_t ext, // Strobes from the decoder
	output logic [7:0] ext_rdata // Read byte
);
	logic [7:0] mem [9'h060:9'h1ff];
	logic [7:0] idle;
	initial
	begin
		for (int i = 'h60; i < 'h200; i++)
			mem[i] = 8'h00;
	end
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			idle <= 8'ha5;
		else
		begin
			idle <= ~idle;
			if (ext.wr)
				mem[ext.addr] <= ext.wdata;
		end
	end
	// Toggling pattern when not read, so a stale byte never passes
	assign ext_rdata = ext.rd ? mem[ext.addr] : idle;
endmodule : iod_ext_model

// file: io_register_space_decoder_tb.sv
/*
 Random self-checking bench of iod_top against a reference model.
 Assumes iod_ext_model stands on the extended space strobes.
*/
`timescale 1ns/1ps
module io_register_space_decoder_tb
	import iod_pkg::*;
();
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	logic pll_lock_raw = 1'b0;
	iod_req_t req = '0;
	iod_port_bytes_t pin_in = '0;
	iod_flag_bytes_t flag_event = '0;
	logic req_ready;
	iod_ans_t ans;
	iod_ext_t ext;
	logic [7:0] ext_rdata;
	iod_note_t note;
	iod_port_bytes_t pin_out;
	iod_port_bytes_t pin_oe_n;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] m [64];
	logic [7:0] em [512];
	logic nt;
	logic [7:0] ntd;

	always #4 clk_sys = ~clk_sys;

	iod_top dut_u (.clk_sys(clk_sys), .resetn(resetn),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.ans(ans), .ext(ext), .ext_rdata(ext_rdata), .note(note),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pll_lock_raw(pll_lock_raw), .flag_event(flag_event));
	iod_ext_model ext_u (.clk_sys(clk_sys), .resetn(resetn), .ext(ext),
		.ext_rdata(ext_rdata));

	// ---------------------------------------------------------
	// Reporting and reference model
	// ---------------------------------------------------------
	task automatic print_verdict;
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_byte

	task automatic cmp_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_bit

	function automatic logic [7:0] wmask(input logic [5:0] a);
		for (int f = 0; f < IOD_FLAG_COUNT; f++)
			if (IOD_FLAG_OFS[f] == a)
				return IOD_FLAG_MASK[f];
		if (a <= 6'h11)
			return (a % 3 == 0) ? 8'h00 : 8'hff;
		case (a)
			6'h1d, 6'h1e, 6'h20, 6'h21, 6'h26, 6'h27, 6'h28: return 8'hff;
			6'h1f: return 8'h3f;
			6'h22: return 8'h0f;
			6'h23: return 8'h83;
			6'h24: return 8'hf3;
			6'h25: return 8'hcf;
			6'h29: return 8'h1e;
			default: return 8'h00;
		endcase
	endfunction : wmask

	function automatic logic [7:0] rdx(input logic [5:0] a);
		if (a <= 6'h11 && a % 3 == 0)
			return pin_in[a / 3];
		if (a == IOD_PLL_CONTROL_STATUS)
			return m[a] | {7'h00, pll_lock_raw};
		return m[a];
	endfunction : rdx

	task automatic mw(input logic [5:0] a, input logic [7:0] d);
		logic fl;
		fl = 1'b0;
		for (int f = 0; f < IOD_FLAG_COUNT; f++)
			if (IOD_FLAG_OFS[f] == a)
				fl = 1'b1;
		if (fl)
			m[a] = m[a] & ~d;
		else
			m[a] = d & wmask(a);
		nt = (a >= 6'h1d && a <= 6'h29);
		ntd = d & wmask(a);
	endtask : mw

	task automatic check_pins;
		for (int p = 0; p < IOD_PORT_COUNT; p++)
		begin
			cmp_byte(pin_out[p], m[IOD_OUT_OFS[p]]);
			cmp_byte(pin_oe_n[p], ~m[IOD_DIR_OFS[p]]);
		end
	endtask : check_pins

	// Entered at a falling edge; returns at the falling edge of the ack
	task automatic acc(input iod_req_t r, output iod_ans_t g);
		int k;
		req = r;
		req_valid = 1'b1;
		for (k = 0; k < 8 && req_ready !== 1'b1; k++)
			@(negedge clk_sys);
		if (k == 8)
			n_fail++;
		@(posedge clk_sys);
		@(negedge clk_sys);
		req_valid = 1'b0;
		for (k = 0; k < 8 && ans.ack !== 1'b1; k++)
			@(negedge clk_sys);
		if (k == 8)
		begin
			n_fail++;
			print_verdict();
		end
		g = ans;
	endtask : acc

	// ---------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------
	initial
	begin
		iod_ans_t g;
		iod_req_t r;
		logic [5:0] io;
		logic er;
		logic sk;
		logic isio;
		logic [7:0] v;
		logic [7:0] ex;
		int a;
		void'($urandom(17370));
		for (int i = 0; i < 64; i++)
			m[i] = 8'h00;
		for (int i = 0; i < 512; i++)
			em[i] = 8'h00;
		for (int p = 0; p < IOD_PORT_COUNT; p++)
			pin_in[p] = 8'($urandom);
		pll_lock_raw = 1'($urandom);
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (3) @(negedge clk_sys);
		check_pins();
		for (int i = 0; i < 400; i++)
		begin
			if ($urandom_range(0, 3) == 0)
			begin
				for (int f = 0; f < IOD_FLAG_COUNT; f++)
				begin
					flag_event[f] = 8'($urandom);
					m[IOD_FLAG_OFS[f]] |= flag_event[f] & IOD_FLAG_MASK[f];
				end
				pin_in = {16'($urandom), 32'($urandom)};
				pll_lock_raw = 1'($urandom);
				@(negedge clk_sys);
				flag_event = '0;
			end
			r.op = iod_op_t'($urandom_range(0, 7));
			r.bitn = 3'($urandom);
			r.wdata = 8'($urandom);
			a = (r.op >= IOD_DATA_LOAD) ? $urandom_range(0, 'h27f) :
				$urandom_range(0, 'h3f);
			r.addr = 16'(a);
			isio = r.op < IOD_DATA_LOAD || (a >= 'h20 && a < 'h60);
			io = (r.op < IOD_DATA_LOAD) ? 6'(a) : 6'(a - 'h20);
			// First half keeps reserved places clean, second writes them unmasked
			if (i < 200)
				r.wdata = r.wdata & wmask(io);
			if (i < 200 && isio && wmask(io) == 8'h00)
				r.op = (r.op >= IOD_DATA_LOAD) ? IOD_DATA_LOAD : IOD_IO_READ;
			er = (r.op >= IOD_DATA_LOAD) ? (a < 'h20 || a > 'h1ff) :
				(r.op >= IOD_SET_BIT_INSTR && io > IOD_BITOP_LAST);
			ex = 8'h00;
			nt = 1'b0;
			v = rdx(io);
			sk = !er && (r.op == IOD_SKIP_IF_BIT_SET_INSTR) == v[r.bitn];
			if (!er)
				case (r.op)
					IOD_IO_READ: ex = v;
					IOD_DATA_LOAD: ex = isio ? v : em[a];
					IOD_IO_WRITE: mw(io, r.wdata);
					IOD_DATA_STORE:
						if (isio)
							mw(io, r.wdata);
						else
							em[a] = r.wdata;
					IOD_SET_BIT_INSTR: mw(io, v | (8'h01 << r.bitn));
					IOD_CLEAR_BIT_INSTR: mw(io, v & ~(8'h01 << r.bitn));
					default: ;
				endcase
			acc(r, g);
			cmp_bit(g.err, er);
			if (r.op == IOD_IO_READ || r.op == IOD_DATA_LOAD ||
				(r.op == IOD_DATA_STORE && !isio))
				cmp_byte(g.rdata, ex);
			if (r.op == IOD_SKIP_IF_BIT_SET_INSTR ||
				r.op == IOD_SKIP_IF_BIT_CLEAR_INSTR)
				cmp_bit(g.skip, sk);
			cmp_bit(note.wr, nt);
			if (nt)
			begin
				cmp_byte(note.data, ntd);
				cmp_byte(8'(note.addr), 8'(io));
			end
			check_pins();
		end
		print_verdict();
	end
endmodule : io_register_space_decoder_tb
